// *** hw/hit_readout_map.svh ***
`ifndef HIT_READOUT_MAP_SVH
`define HIT_READOUT_MAP_SVH

// ==========================================================================
// Register map, byte addresses
`define HR_ADDR_MASK0      8'h00
`define HR_ADDR_CTRL       8'h20
`define HR_ADDR_LAT        8'h24
`define HR_ADDR_STAT       8'h28
`define HR_MASK_WORDS      8

// ==========================================================================
// Control word fields
`define HR_PHASE_LSB       0
`define HR_PHASE_W         5
`define HR_STUB_SEL_LSB    8
`define HR_PIPE_SEL_LSB    12
`define HR_HIP_SRC_BIT     16
`define HR_HIP_LEN_LSB     20
`define HR_HIP_LEN_W       3
`define HR_ANY_EN_BIT      24

// ==========================================================================
// Status word fields
`define HR_ST_WR_LSB       0
`define HR_ST_TRIG_LSB     9
`define HR_ST_OCC_LSB      18
`define HR_ST_LERR_BIT     24
`define HR_ST_FULL_BIT     25
`define HR_ST_WRUN_BIT     26
`define HR_ST_TRUN_BIT     27

// ==========================================================================
// Reset values
`define HR_CTRL_RST        32'h0000_1100
`define HR_LAT_RST         9'h001

// ==========================================================================
// Fast command bits, frame layout, timing
`define HR_FC_RESET_BIT    0
`define HR_FC_TRIG_BIT     1
`define HR_FRAME_HDR       2'h3
`define HR_FRAME_LEN       267
`define HR_ADDR_CODE_W     13
`define HR_CLK_NS          10
`define HR_PHASE_STEP_NS   1

`endif

// *** hw/hit_readout_pkg.sv ***
package hit_readout_pkg;

	// Hit-detect result selection
	typedef enum logic [1:0] {
		HM_FIXED,
		HM_SAMPLED,
		HM_OR,
		HM_HIP
	} hit_mode_t;

	// Output serialiser sequence
	typedef enum logic {
		SER_IDLE,
		SER_SHIFT
	} ser_state_t;

endpackage : hit_readout_pkg

// *** hw/hit_detect_pipeline_readout.sv ***
// Overview of operation
// - Shift derived clock phase, 1ns steps, 0-25ns
// - Phase setting zero bypasses the delay
// - Fast commands delayed exactly like the clock
// - Mask bit set holds channel hit low
// - Masked channel gives zero data, no stubs
// - Fixed mode: rising edge only, one-period pulse
// - Fixed mode needs comparator low between hits
// - Sampled mode registers comparator each clock edge
// - Combined mode ORs fixed and sampled results
// - Suppression forces low after programmed length
// - Suppression source: sampled or combined result
// - Stub and pipeline sources chosen independently
// - OR all pipeline hits into any-hit flag
// - Pipeline 512 by 254, concurrent write/read
// - Pipeline control started only by fast reset
// - Nine-bit write pointer decoded one-hot to rows
// - Write counter from 0 to 511, wraps
// - Trigger counter starts after programmed latency
// - Pointer difference checked, latency error flagged
// - Trigger copies pipeline row plus address
// - Empty buffer blocks serialiser load; a loaded frame still shifts out
// - Occupancy counter, full at 32, flags after header
// - Buffer holds 32 events of 267 bits
`timescale 1ns/1ns
`include "hit_readout_map.svh"

module hit_detect_pipeline_readout #(
	parameter int NCH   = 254,
	parameter int DEPTH = 512,
	parameter int PW    = 9,
	parameter int BUFD  = 32,
	parameter int BW    = 5
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             srst,
	// Configuration port
	input  wire logic [7:0]       reg_addr,
	input  wire logic [31:0]      reg_wdata,
	input  wire logic             reg_wr,
	input  wire logic             reg_rd,
	output logic      [31:0]      reg_rdata,
	// Fast command link
	input  wire logic             link_clk,
	input  wire logic [1:0]       fast_command_port,
	// Comparators
	input  wire logic [NCH-1:0]   comp_in,
	// Results
	output logic      [NCH-1:0]   stub_hits,
	output logic                  any_hit_flag,
	output logic                  ser_data,
	output logic                  ser_frame
);

	// ======================================================================
	// Configuration storage
	logic [NCH-1:0] mask_r;
	logic [31:0]    ctrl_r;
	logic [PW-1:0]  lat_r;
	logic [`HR_PHASE_W-1:0]   phase;
	logic [`HR_HIP_LEN_W-1:0] hip_len;
	hit_readout_pkg::hit_mode_t stub_mode;
	hit_readout_pkg::hit_mode_t pipe_mode;
	logic           hip_src;
	logic           any_en;

	assign phase     = ctrl_r[`HR_PHASE_LSB +: `HR_PHASE_W];
	assign hip_len   = ctrl_r[`HR_HIP_LEN_LSB +: `HR_HIP_LEN_W];
	assign stub_mode = hit_readout_pkg::hit_mode_t'(
		ctrl_r[`HR_STUB_SEL_LSB +: 2]);
	assign pipe_mode = hit_readout_pkg::hit_mode_t'(
		ctrl_r[`HR_PIPE_SEL_LSB +: 2]);
	assign hip_src   = ctrl_r[`HR_HIP_SRC_BIT];
	assign any_en    = ctrl_r[`HR_ANY_EN_BIT];

	always_ff @(posedge clk) begin
		if (srst) begin
			mask_r <= '0;
			ctrl_r <= `HR_CTRL_RST;
			lat_r  <= `HR_LAT_RST;
		end else if (reg_wr) begin
			if (reg_addr == `HR_ADDR_CTRL)
				ctrl_r <= reg_wdata;
			if (reg_addr == `HR_ADDR_LAT)
				lat_r <= reg_wdata[PW-1:0];
			for (int i = 0; i < NCH; i++) begin
				if (reg_addr[7:2] == 6'(i / 32))
					mask_r[i] <= reg_wdata[i % 32];
			end
		end
	end

	// ======================================================================
	// Input synchronisers
	logic           lk_s1, lk_s2, lk_d;
	logic [1:0]     fc_s1, fc_s2;
	logic [NCH-1:0] comp_s1, comp_s2, comp_d;

	always_ff @(posedge clk) begin
		lk_s1   <= link_clk;
		lk_s2   <= lk_s1;
		lk_d    <= lk_s2;
		fc_s1   <= fast_command_port;
		fc_s2   <= fc_s1;
		comp_s1 <= comp_in;
		comp_s2 <= comp_s1;
		comp_d  <= comp_s2;
	end

	// ======================================================================
	// Phase shifter: one system clock is ten steps here, so finer steps
	// round up; the commands ride the same delay so they stay aligned.
	function automatic logic [2:0] phase_cycles(input logic [4:0] p);
		int c;
		c = (int'(p) * `HR_PHASE_STEP_NS + `HR_CLK_NS - 1) / `HR_CLK_NS;
		if (c < 1)
			c = 1;
		return 3'(c);
	endfunction : phase_cycles

	logic       raw_tick;
	logic [2:0] dly_r;
	logic [1:0] cmd_hold_r;
	logic       bx_r;
	logic [1:0] bx_cmd_r;

	assign raw_tick = lk_s2 & ~lk_d;

	always_ff @(posedge clk) begin
		if (srst) begin
			dly_r      <= '0;
			cmd_hold_r <= '0;
			bx_r       <= 1'b0;
			bx_cmd_r   <= '0;
		end else begin
			bx_r <= 1'b0;
			if (raw_tick) begin
				if (phase == '0) begin
					bx_r     <= 1'b1;
					bx_cmd_r <= fc_s2;
					dly_r    <= '0;
				end else begin
					dly_r      <= phase_cycles(phase);
					cmd_hold_r <= fc_s2;
				end
			end else if (dly_r != '0) begin
				dly_r <= dly_r - 3'h1;
				if (dly_r == 3'h1) begin
					bx_r     <= 1'b1;
					bx_cmd_r <= cmd_hold_r;
				end
			end
		end
	end

	logic fast_rst, trig_cmd;
	assign fast_rst = bx_r & bx_cmd_r[`HR_FC_RESET_BIT];
	assign trig_cmd = bx_r & bx_cmd_r[`HR_FC_TRIG_BIT];

	// ======================================================================
	// Hit detect, one slice per channel
	function automatic logic pick(input hit_readout_pkg::hit_mode_t m,
		input logic fw, input logic smp, input logic hp);
		case (m)
			hit_readout_pkg::HM_FIXED:   pick = fw;
			hit_readout_pkg::HM_SAMPLED: pick = smp;
			hit_readout_pkg::HM_OR:      pick = fw | smp;
			hit_readout_pkg::HM_HIP:     pick = hp;
			default:                     pick = 1'b0;
		endcase
	endfunction : pick

	logic [NCH-1:0] pipe_hit;

	for (genvar i = 0; i < NCH; i++) begin : g_ch
		logic       rise, pend_r, fw_r, smp_r, hip_in;
		logic [2:0] hcnt_r;
		logic       hp;

		// Edge capture catches pulses shorter than a period
		assign rise   = comp_s2[i] & ~comp_d[i];
		assign hip_in = hip_src ? (fw_r | smp_r) : smp_r;
		assign hp     = hip_in & (hcnt_r < hip_len);

		always_ff @(posedge clk) begin
			if (srst) begin
				pend_r <= 1'b0;
				fw_r   <= 1'b0;
				smp_r  <= 1'b0;
				hcnt_r <= '0;
			end else if (bx_r) begin
				fw_r   <= pend_r | rise;
				pend_r <= 1'b0;
				smp_r  <= comp_s2[i];
				if (!hip_in)
					hcnt_r <= '0;
				else if (hcnt_r != 3'h7)
					hcnt_r <= hcnt_r + 3'h1;
			end else if (rise) begin
				pend_r <= 1'b1;
			end
		end

		// Masked channels stay silent on both paths
		assign pipe_hit[i] = ~mask_r[i] &
			pick(pipe_mode, fw_r, smp_r, hp);

		always_ff @(posedge clk) begin
			if (srst)
				stub_hits[i] <= 1'b0;
			else
				stub_hits[i] <= ~mask_r[i] &
					pick(stub_mode, fw_r, smp_r, hp);
		end
	end

	always_ff @(posedge clk) begin
		if (srst)
			any_hit_flag <= 1'b0;
		else
			any_hit_flag <= any_en & (|pipe_hit);
	end

	// ======================================================================
	// Pipeline memory and pointers
	logic [NCH-1:0] mem_r [DEPTH];
	logic [PW-1:0]  wr_ptr_r, trig_ptr_r;
	logic           wr_run_r, trig_run_r;
	logic [DEPTH-1:0] wr_row;
	logic           lat_err;

	function automatic logic [DEPTH-1:0] row_dec(input logic [PW-1:0] p);
		row_dec = '0;
		row_dec[p] = 1'b1;
	endfunction : row_dec

	assign wr_row  = row_dec(wr_ptr_r);
	assign lat_err = trig_run_r &&
		(PW'(wr_ptr_r - trig_ptr_r) != lat_r);

	for (genvar r = 0; r < DEPTH; r++) begin : g_row
		always_ff @(posedge clk) begin
			if (bx_r && wr_run_r && wr_row[r])
				mem_r[r] <= pipe_hit;
		end
	end

	// Pointers idle after power-up until the first fast reset
	always_ff @(posedge clk) begin
		if (srst) begin
			wr_ptr_r   <= '0;
			trig_ptr_r <= '0;
			wr_run_r   <= 1'b0;
			trig_run_r <= 1'b0;
		end else if (fast_rst) begin
			wr_ptr_r   <= '0;
			trig_ptr_r <= '0;
			wr_run_r   <= 1'b1;
			trig_run_r <= (lat_r == '0);
		end else if (bx_r && wr_run_r) begin
			wr_ptr_r <= wr_ptr_r + PW'(1);
			if (trig_run_r)
				trig_ptr_r <= trig_ptr_r + PW'(1);
			else if (PW'(wr_ptr_r + PW'(1)) == lat_r)
				trig_run_r <= 1'b1;
		end
	end

	// ======================================================================
	// Address protection code, single error correcting
	function automatic logic [12:0] ham_enc(input logic [8:0] d);
		logic [12:0] c;
		int k;
		c = '0;
		k = 0;
		for (int p = 1; p <= 13; p++) begin
			if ((p & (p - 1)) != 0) begin
				c[p-1] = d[k];
				k++;
			end
		end
		for (int b = 0; b < 4; b++) begin
			for (int p = 1; p <= 13; p++) begin
				if (((p >> b) & 1) == 1)
					c[(1 << b) - 1] = c[(1 << b) - 1] ^ c[p-1];
			end
		end
		return c;
	endfunction : ham_enc

	function automatic logic [8:0] ham_dec(input logic [12:0] c);
		logic [12:0] f;
		logic [3:0]  s;
		logic [8:0]  d;
		int k;
		s = '0;
		d = '0;
		k = 0;
		for (int p = 1; p <= 13; p++) begin
			if (c[p-1])
				s = s ^ 4'(p);
		end
		f = c;
		if (s != '0 && s <= 4'hd)
			f[s-1] = ~f[s-1];
		for (int p = 1; p <= 13; p++) begin
			if ((p & (p - 1)) != 0) begin
				d[k] = f[p-1];
				k++;
			end
		end
		return d;
	endfunction : ham_dec

	// ======================================================================
	// Output buffer
	localparam int EW = NCH + `HR_ADDR_CODE_W;
	logic [EW-1:0] buf_r [BUFD];
	logic          buf_err_r [BUFD];
	logic [BW-1:0] bwp_r, brp_r;
	logic [BW:0]   occ_r;
	logic          full;
	logic          push, pop;

	assign full = (occ_r == (BW+1)'(BUFD));
	// A trigger into a full buffer is dropped
	assign push = trig_cmd && wr_run_r && !full;

	always_ff @(posedge clk) begin
		if (push) begin
			buf_r[bwp_r] <= {ham_enc(trig_ptr_r),
				mem_r[trig_ptr_r]};
			buf_err_r[bwp_r] <= lat_err;
		end
	end

	always_ff @(posedge clk) begin
		if (srst || fast_rst) begin
			bwp_r <= '0;
			brp_r <= '0;
			occ_r <= '0;
		end else begin
			if (push)
				bwp_r <= bwp_r + BW'(1);
			if (pop)
				brp_r <= brp_r + BW'(1);
			occ_r <= occ_r + (BW+1)'(push) - (BW+1)'(pop);
		end
	end

	// ======================================================================
	// Output shift register
	localparam int FL = `HR_FRAME_LEN;
	hit_readout_pkg::ser_state_t ser_st_r;
	logic [FL-1:0] shift_r, load_word;
	logic [8:0]    bit_cnt_r;
	logic [EW-1:0] head;

	assign head = buf_r[brp_r];
	assign pop  = (ser_st_r == hit_readout_pkg::SER_IDLE) &&
		(occ_r != '0) && !fast_rst;

	always_comb begin
		load_word = '0;
		load_word[FL-1 -: 4] = {`HR_FRAME_HDR, buf_err_r[brp_r],
			full};
		load_word[FL-5 -: 9] = ham_dec(head[EW-1 -: `HR_ADDR_CODE_W]);
		// Channel one leaves first
		for (int i = 0; i < NCH; i++)
			load_word[NCH-1-i] = head[i];
	end

	always_ff @(posedge clk) begin
		if (srst || fast_rst) begin
			ser_st_r  <= hit_readout_pkg::SER_IDLE;
			shift_r   <= '0;
			bit_cnt_r <= '0;
			ser_data  <= 1'b0;
			ser_frame <= 1'b0;
		end else begin
			case (ser_st_r)
				hit_readout_pkg::SER_IDLE: begin
					ser_data  <= 1'b0;
					ser_frame <= 1'b0;
					if (pop) begin
						shift_r   <= load_word;
						bit_cnt_r <= 9'(FL - 1);
						ser_st_r  <= hit_readout_pkg::SER_SHIFT;
					end
				end
				hit_readout_pkg::SER_SHIFT: begin
					ser_data  <= shift_r[FL-1];
					ser_frame <= 1'b1;
					shift_r   <= {shift_r[FL-2:0], 1'b0};
					bit_cnt_r <= bit_cnt_r - 9'h1;
					if (bit_cnt_r == '0)
						ser_st_r <= hit_readout_pkg::SER_IDLE;
				end
				default: ser_st_r <= hit_readout_pkg::SER_IDLE;
			endcase
		end
	end

	// ======================================================================
	// Read-back
	always_ff @(posedge clk) begin
		if (srst || !reg_rd) begin
			reg_rdata <= '0;
		end else begin
			reg_rdata <= '0;
			if (reg_addr == `HR_ADDR_CTRL)
				reg_rdata <= ctrl_r;
			else if (reg_addr == `HR_ADDR_LAT)
				reg_rdata <= 32'(lat_r);
			else if (reg_addr == `HR_ADDR_STAT) begin
				reg_rdata[`HR_ST_WR_LSB +: PW]   <= wr_ptr_r;
				reg_rdata[`HR_ST_TRIG_LSB +: PW] <= trig_ptr_r;
				reg_rdata[`HR_ST_OCC_LSB +: BW+1] <= occ_r;
				reg_rdata[`HR_ST_LERR_BIT] <= lat_err;
				reg_rdata[`HR_ST_FULL_BIT] <= full;
				reg_rdata[`HR_ST_WRUN_BIT] <= wr_run_r;
				reg_rdata[`HR_ST_TRUN_BIT] <= trig_run_r;
			end else begin
				for (int i = 0; i < NCH; i++) begin
					if (reg_addr[7:2] == 6'(i / 32))
						reg_rdata[i % 32] <= mask_r[i];
				end
			end
		end
	end

endmodule : hit_detect_pipeline_readout

// *** verification/hit_readout_properties.sv ***
`timescale 1ns/1ns
module hit_readout_properties #(
	parameter int NCH = 254
) (
	// Clock and reset
	input wire logic             clk,
	input wire logic             srst,
	// Configuration port
	input wire logic [7:0]       reg_addr,
	input wire logic [31:0]      reg_wdata,
	input wire logic             reg_wr,
	input wire logic             reg_rd,
	input wire logic [31:0]      reg_rdata,
	// Fast command link
	input wire logic [1:0]       fast_command_port,
	// Results
	input wire logic [NCH-1:0]   stub_hits,
	input wire logic             any_hit_flag,
	input wire logic             ser_data,
	input wire logic             ser_frame
);
	logic [31:0] mask_lo_r;
	logic        any_en_r;
	logic [5:0]  quiet_r;
	logic [8:0]  frame_cnt_r;
	logic [4:0]  near_rst_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	// ==========
	// Shadows of mask word 0 and any-hit enable
	always_ff @(posedge clk) begin
		if (srst)
			mask_lo_r <= 32'h0;
		else if (reg_wr && reg_addr == 8'h00)
			mask_lo_r <= reg_wdata;
	end

	always_ff @(posedge clk) begin
		if (srst)
			any_en_r <= 1'b0;
		else if (reg_wr && reg_addr == 8'h20)
			any_en_r <= reg_wdata[24];
	end

	// Hit results move only on a bx tick, so wait for settling
	always_ff @(posedge clk) begin
		if (srst || reg_wr)
			quiet_r <= 6'h0;
		else if (quiet_r != 6'h3f)
			quiet_r <= quiet_r + 6'h1;
	end

	always_ff @(posedge clk) begin
		if (srst || !ser_frame)
			frame_cnt_r <= 9'h0;
		else
			frame_cnt_r <= frame_cnt_r + 9'h1;
	end

	// A fast reset may legally cut a frame short
	always_ff @(posedge clk) begin
		if (srst)
			near_rst_r <= 5'h0;
		else if (fast_command_port[0])
			near_rst_r <= 5'h1f;
		else if (near_rst_r != 5'h0)
			near_rst_r <= near_rst_r - 5'h1;
	end

	// ==========
	// Properties
	chk_rd_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside read slot");
	chk_unmapped_zero: assert property ($past(reg_rd) && $past(reg_addr) > 8'h28 |-> reg_rdata == 32'h0)
		else $error("unmapped read not zero");
	chk_mask_top: assert property ($past(reg_rd) && $past(reg_addr) == 8'h1c |-> reg_rdata[31:30] == 2'h0)
		else $error("unused mask bits read back");
	chk_ser_idle: assert property (!ser_frame |-> !ser_data)
		else $error("serial data outside frame");
	chk_frame_header: assert property ($rose(ser_frame) |-> ser_data ##1 ser_data)
		else $error("frame header not 11");
	chk_frame_len: assert property ($fell(ser_frame) && near_rst_r == 5'h0 |-> $past(frame_cnt_r) == 9'd266)
		else $error("frame length wrong");
	chk_frame_max: assert property (ser_frame |-> frame_cnt_r < 9'd267)
		else $error("frame too long");
	chk_mask_hold: assert property (quiet_r == 6'h3f |-> (stub_hits[31:0] & mask_lo_r) == 32'h0)
		else $error("masked channel hit");
	chk_any_off: assert property (quiet_r == 6'h3f && !any_en_r |-> !any_hit_flag)
		else $error("any-hit flag while disabled");

	cover property ($rose(ser_frame));
	cover property (any_hit_flag);
	cover property ($past(reg_rd) && $past(reg_addr) == 8'h28);
endmodule : hit_readout_properties

bind hit_detect_pipeline_readout hit_readout_properties #(
	.NCH(NCH)
) i_props (
	.clk          (clk),
	.srst         (srst),
	.reg_addr     (reg_addr),
	.reg_wdata    (reg_wdata),
	.reg_wr       (reg_wr),
	.reg_rd       (reg_rd),
	.reg_rdata    (reg_rdata),
	.fast_command_port (fast_command_port),
	.stub_hits    (stub_hits),
	.any_hit_flag (any_hit_flag),
	.ser_data     (ser_data),
	.ser_frame    (ser_frame)
);

// *** verification/fast_ctrl_model.sv ***
`timescale 1ns/1ns
module fast_ctrl_model (
	// Command request from bench
	input  wire logic [1:0] cmd,
	// Link to device
	output logic            link_clk,
	output logic [1:0]      fast_command_port
);
	// ==========
	// Derived clock runs continuously, the write pointer steps on every tick after a fast reset
	// Command changes on the falling edge so it stands across the rising one
	initial begin
		link_clk = 1'b0;
		fast_command_port = 2'h0;
		forever begin
			#80 link_clk = 1'b1;
			#80 link_clk = 1'b0;
			fast_command_port <= cmd;
		end
	end
endmodule : fast_ctrl_model

// *** verification/tb.sv ***
`timescale 1ns/1ns
module tb;
	logic         clk, srst, reg_wr, reg_rd, link_clk;
	logic         any_hit_flag, ser_data, ser_frame;
	logic [7:0]   reg_addr;
	logic [31:0]  reg_wdata, reg_rdata, d;
	logic [1:0]   cmd, fast_command_port;
	logic [253:0] comp_in, stub_hits, v;
	logic [255:0] mw, c;
	logic [266:0] f;
	logic [8:0]   w0;
	int           fails, check_count, lat, sel;

	hit_detect_pipeline_readout i_hit_detect_pipeline_readout (
		.clk               (clk),
		.srst              (srst),
		.reg_addr          (reg_addr),
		.reg_wdata         (reg_wdata),
		.reg_wr            (reg_wr),
		.reg_rd            (reg_rd),
		.reg_rdata         (reg_rdata),
		.link_clk          (link_clk),
		.fast_command_port (fast_command_port),
		.comp_in           (comp_in),
		.stub_hits         (stub_hits),
		.any_hit_flag      (any_hit_flag),
		.ser_data          (ser_data),
		.ser_frame         (ser_frame)
	);

	fast_ctrl_model i_fast_ctrl_model (
		.cmd               (cmd),
		.link_clk          (link_clk),
		.fast_command_port (fast_command_port)
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ==========
	// Bus, link and checking helpers
	task automatic wr(input logic [7:0] a, input logic [31:0] x);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= x;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd

	task automatic send(input logic [1:0] x);
		@(posedge clk);
		cmd <= x;
		@(negedge link_clk);
		@(posedge clk);
		cmd <= 2'h0;
	endtask : send

	task automatic chk(input string n, input logic [266:0] s, e);
		check_count++;
		if (s !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task automatic tally_and_finish;
		if (fails == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : tally_and_finish

	// Channel 1 leaves first, so it lands highest in the capture
	function automatic logic [253:0] rev(input logic [253:0] x);
		for (int i = 0; i < 254; i++)
			rev[253 - i] = x[i];
	endfunction : rev

	// Constant input: fixed pulse is gone, suppression has cut in
	function automatic logic [253:0] stub_exp(input int s, logic [253:0] x);
		return (s == 1 || s == 2) ? x : '0;
	endfunction : stub_exp

	// ==========
	// Main sequence
	initial begin
		srst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		cmd = 2'h0;
		comp_in = '0;
		void'($urandom(21));
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		rd(8'h20);
		chk("ctrl", d, 32'h0000_1100);
		rd(8'h24);
		chk("latency", d, 32'h1);
		rd(8'h40);
		chk("unmapped", d, 32'h0);
		rd(8'h28);
		chk("idle", d[26], 1'b0);
		for (int it = 0; it < 4; it++) begin
			// First pass: no mask, every channel hit
			for (int k = 0; k < 8; k++) begin
				mw[32*k +: 32] = it == 0 ? 32'h0 : $urandom;
				c[32*k +: 32] = it == 0 ? 32'hffff_ffff : $urandom;
				wr(8'(4*k), mw[32*k +: 32]);
			end
			for (int k = 0; k < 8; k++) begin
				rd(8'(4*k));
				chk("mask", d, k == 7 ? {2'h0, mw[253:224]} : mw[32*k +: 32]);
			end
			v = c[253:0] & ~mw[253:0];
			sel = (it + 1) % 4;
			lat = 1 + $urandom % 40;
			wr(8'h24, 32'(lat));
			wr(8'h20, {7'h0, 2'h2, 3'($urandom), 3'h0, 1'($urandom), 4'h1,
				2'h0, 2'(sel), 3'h0,
				5'(it == 0 ? 0 : $urandom % 26)});
			comp_in <= c[253:0];
			// Longest suppression needs eight ticks plus sync and phase
			repeat (160) @(posedge clk);
			chk("stub", stub_hits, stub_exp(sel, v));
			chk("any hit", any_hit_flag, |v);
			send(2'h1);
			repeat ((lat + 4) * 16) @(posedge clk);
			rd(8'h28);
			chk("status", d[27:24], 4'hc);
			chk("gap", 9'(d[8:0] - d[17:9]), 9'(lat));
			w0 = d[8:0];
			repeat (158) @(posedge clk);
			rd(8'h28);
			chk("advance", 9'(d[8:0] - w0), 9'd10);
			send(2'h2);
			for (int t = 0; t < 600 && ser_frame !== 1'b1; t++)
				@(negedge clk);
			if (ser_frame !== 1'b1) begin
				fails++;
				tally_and_finish();
			end
			for (int b = 0; b < 267; b++) begin
				f = {f[265:0], ser_data};
				@(negedge clk);
			end
			chk("header", f[266:263], 4'hc);
			chk("channels", f[253:0], rev(v));
			chk("frame end", ser_frame, 1'b0);
		end
		tally_and_finish();
	end
endmodule : tb
